// File: core/prio_misc_pkg.sv
// package: constants, types and the behaviour list for the
// priority and system-misc control block; assumes an APB master.
// Behaviour
// - a four-bit select field promotes one I-maskable source to top I priority
// - codes 0-7: tovf, paovf, paedge, spi, sci, reserved=irq, irq, rti
// - codes 8-D: ic1-3, oc1-3; E: ic4/oc5; F: oc4
// - select field writes are ignored while the I mask bit is clear
// - reset loads the select field with 0101, promoting the irq pin
// - promoted source keeps its vector and stays gated by local enable and I
// - boot rom enable readable, writable only in special mode, reset per mode
// - boot rom answers at BF00-BFFF only while enabled
// - special and mode-a bits readable, caught from mode pins at reset release
// - pins b,a: 10 single, 11 expanded, 00 bootstrap, 01 test
// - special bit writable in special modes, never set again once cleared
// - mode-a bit: any writes in special modes, first write only in normal
// - visibility/clock-off bit readable, one write after reset in any mode
// - visibility/clock-off bit resets set in test mode, clear otherwise
// - in expanded modes the bit drives internal read data onto the bus
// - stop halts clocks only when the S bit is clear
// - irq pin low wakes stop only when I is clear
// - nmi pin low always wakes stop; X clear services it, X set resumes
// - reset pin low always ends stop and restarts from the reset vector
// - stop exit waits a restart delay when delay enable set; reset sets it
// - wait stacks state and halts until an unmasked interrupt or reset
// - in wait with I set and watchdog off, the timer system is shut off
package prio_misc_pkg;
  localparam logic [11:0] ADDR_PRIO_MISC   = 12'h000;
  localparam logic [11:0] ADDR_LOWPWR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_LOWPWR_STAT = 12'h008;
  localparam int BIT_BOOT    = 7;
  localparam int BIT_SPECIAL = 6;
  localparam int BIT_MODE_A  = 5;
  localparam int BIT_VIS     = 4;
  localparam logic [3:0] PSEL_RESET = 4'h5;
  localparam logic [3:0] PSEL_IRQ   = 4'h6;
  localparam logic [15:0] BOOT_LO = 16'hBF00;
  localparam logic [15:0] BOOT_HI = 16'hBFFF;
  localparam int CLK_HZ          = 40000000;
  localparam int RESTART_DLY_US  = 100;
  localparam int RESTART_DLY_CYC = (CLK_HZ / 1000000) * RESTART_DLY_US;
  localparam int NSRC = 16;
  typedef enum logic [4:0] {
    PM_RUN   = 5'b00001,
    PM_STOP  = 5'b00010,
    PM_DELAY = 5'b00100,
    PM_WAIT  = 5'b01000,
    PM_RESUME= 5'b10000
  } pm_state_e;
  typedef struct packed {
    logic       s_bit;
    logic       x_bit;
    logic       i_bit;
  } ccr_s;
  typedef struct packed {
    logic       stop_exec;
    logic       wait_exec;
  } cpu_op_s;
endpackage

// File: core/prio_misc_ctrl.sv
// priority promotion, mode/misc register and stop/wait sequencer
// assumes APB slave access at ADDR_*, pins already synchronous to CLK_I.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module prio_misc_ctrl #(
  parameter int RESTART_CYCLES = prio_misc_pkg::RESTART_DLY_CYC
) (
  // clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    SRST_I,
  // apb slave
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [11:0]             PADDR_I,
  input  wire logic [31:0]             PWDATA_I,
  output logic      [31:0]             PRDATA_O,
  output logic                         PREADY_O,
  output logic                         PSLVERR_O,
  // cpu side
  input  wire prio_misc_pkg::ccr_s     CCR_I,
  input  wire prio_misc_pkg::cpu_op_s  OP_I,
  input  wire logic [15:0]             CPU_ADDR_I,
  input  wire logic                    INT_READ_I,
  input  wire logic [prio_misc_pkg::NSRC-1:0] SRC_REQ_I,
  input  wire logic [prio_misc_pkg::NSRC-1:0] SRC_EN_I,
  input  wire logic                    WDOG_EN_I,
  // pins
  input  wire logic                    MODE_PIN_A_I,
  input  wire logic                    MODE_PIN_B_I,
  input  wire logic                    IRQ_N_I,
  input  wire logic                    NMI_N_I,
  input  wire logic                    RST_PIN_N_I,
  input  wire logic                    BUS_CLK_I,
  // outputs
  output logic      [3:0]              TOP_SRC_O,
  output logic                         TOP_VALID_O,
  output logic                         BOOT_SEL_O,
  output logic                         VIS_DRIVE_O,
  output logic                         BUS_CLK_O,
  output logic                         CLK_HALT_O,
  output logic                         TIMER_OFF_O,
  output logic                         WAKE_SERVICE_O,
  output logic                         WAKE_RESUME_O,
  output logic                         WAKE_RESET_O
);
  import prio_misc_pkg::*;

  logic [3:0] psel_q;
  logic boot_q, special_q, mode_a_q, vis_q, dly_en_q;
  logic mode_a_wr_q, vis_wr_q, init_q;
  pm_state_e pm_q;
  logic [31:0] dly_cnt_q;
  logic [4:0] stat_v;

  // write only at the completing edge of an access
  wire wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  wire rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I;
  wire wr_misc = wr_acc & (PADDR_I == ADDR_PRIO_MISC);
  wire wr_ctrl = wr_acc & (PADDR_I == ADDR_LOWPWR_CTRL);
  // special modes are decoded from the live special bit
  wire spec_mode = special_q;
  // expanded modes: mode a bit high (expanded or test)
  wire expanded = mode_a_q;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == ADDR_PRIO_MISC) || (a == ADDR_LOWPWR_CTRL) ||
                 (a == ADDR_LOWPWR_STAT);
  endfunction

  // mode bits caught one clock after reset release: a flop held in reset may not
  // take a pin value, so init_q marks the first free cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      special_q <= 1'b0;
      mode_a_q  <= 1'b0;
    end else if (init_q) begin
      special_q <= ~MODE_PIN_B_I;
      mode_a_q  <= MODE_PIN_A_I;
    end else if (wr_misc) begin
      if (spec_mode && !PWDATA_I[BIT_SPECIAL])
        special_q <= 1'b0;
      if (spec_mode || !mode_a_wr_q)
        mode_a_q <= PWDATA_I[BIT_MODE_A];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_a_wr_q <= 1'b0;
      vis_wr_q    <= 1'b0;
    end else if (wr_misc) begin
      mode_a_wr_q <= 1'b1;
      vis_wr_q    <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      boot_q <= 1'b0;
      vis_q  <= 1'b0;
    end else if (init_q) begin
      boot_q <= ~MODE_PIN_B_I & ~MODE_PIN_A_I;
      vis_q  <= ~MODE_PIN_B_I & MODE_PIN_A_I;
    end else if (wr_misc) begin
      if (spec_mode)
        boot_q <= PWDATA_I[BIT_BOOT];
      if (!vis_wr_q)
        vis_q <= PWDATA_I[BIT_VIS];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      psel_q <= PSEL_RESET;
    end else if (wr_misc && CCR_I.i_bit) begin
      psel_q <= PWDATA_I[3:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      dly_en_q <= 1'b1;
    end else if (wr_ctrl) begin
      dly_en_q <= PWDATA_I[0];
    end
  end

  // promoted source: reserved code maps to the irq slot
  logic [3:0] psel_eff;
  always_comb begin
    psel_eff = (psel_q == PSEL_RESET) ? PSEL_IRQ : psel_q;
  end

  // promotion only reorders; source keeps its vector and masks
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      TOP_SRC_O   <= 4'h0;
      TOP_VALID_O <= 1'b0;
    end else begin
      TOP_SRC_O   <= psel_eff;
      TOP_VALID_O <= SRC_REQ_I[psel_eff] & SRC_EN_I[psel_eff] &
                     ~CCR_I.i_bit;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      BOOT_SEL_O  <= 1'b0;
      VIS_DRIVE_O <= 1'b0;
      BUS_CLK_O   <= 1'b0;
    end else begin
      BOOT_SEL_O  <= boot_q && CPU_ADDR_I >= BOOT_LO &&
                     CPU_ADDR_I <= BOOT_HI;
      // outside parties must keep off the bus while this is high
      VIS_DRIVE_O <= expanded & vis_q & INT_READ_I;
      BUS_CLK_O   <= (!expanded && vis_q) ? 1'b0 : BUS_CLK_I;
    end
  end

  // low-power sequencer
  wire irq_wake = ~IRQ_N_I & ~CCR_I.i_bit;
  wire nmi_wake = ~NMI_N_I;
  wire any_int  = irq_wake | nmi_wake | (|(SRC_REQ_I & SRC_EN_I) &
                  ~CCR_I.i_bit);
  logic svc_q;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pm_q      <= PM_RUN;
      dly_cnt_q <= 32'h0;
      svc_q     <= 1'b0;
    end else if (!RST_PIN_N_I) begin
      pm_q <= PM_RUN;
    end else begin
      case (pm_q)
        PM_RUN: begin
          if (OP_I.stop_exec && !CCR_I.s_bit)
            pm_q <= PM_STOP;
          else if (OP_I.wait_exec)
            pm_q <= PM_WAIT;
        end
        PM_STOP: begin
          if (irq_wake || nmi_wake) begin
            svc_q     <= irq_wake | (nmi_wake & ~CCR_I.x_bit);
            dly_cnt_q <= 32'(RESTART_CYCLES - 1);
            pm_q      <= dly_en_q ? PM_DELAY : PM_RESUME;
          end
        end
        PM_DELAY: begin
          if (dly_cnt_q == 32'h0)
            pm_q <= PM_RESUME;
          else
            dly_cnt_q <= dly_cnt_q - 32'h1;
        end
        PM_WAIT: begin
          if (any_int) begin
            svc_q <= 1'b1;
            pm_q  <= PM_RESUME;
          end
        end
        PM_RESUME: pm_q <= PM_RUN;
        default:   pm_q <= PM_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      CLK_HALT_O     <= 1'b0;
      TIMER_OFF_O    <= 1'b0;
      WAKE_SERVICE_O <= 1'b0;
      WAKE_RESUME_O  <= 1'b0;
      WAKE_RESET_O   <= 1'b0;
    end else begin
      CLK_HALT_O     <= (pm_q == PM_STOP) || (pm_q == PM_DELAY);
      TIMER_OFF_O    <= (pm_q == PM_WAIT) && CCR_I.i_bit &&
                        !WDOG_EN_I;
      WAKE_SERVICE_O <= (pm_q == PM_RESUME) && svc_q;
      WAKE_RESUME_O  <= (pm_q == PM_RESUME) && !svc_q;
      WAKE_RESET_O   <= !RST_PIN_N_I && (pm_q != PM_RUN);
    end
  end

  always_comb begin
    stat_v = pm_q;
  end

  // apb: zero wait state; unknown addresses read zero with an error
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O  <= 32'h0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_known(PADDR_I);
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
        if (PADDR_I == ADDR_PRIO_MISC)
          PRDATA_O <= {24'h0, boot_q, special_q, mode_a_q, vis_q,
                       psel_q};
        else if (PADDR_I == ADDR_LOWPWR_CTRL)
          PRDATA_O <= {31'h0, dly_en_q};
        else if (PADDR_I == ADDR_LOWPWR_STAT)
          PRDATA_O <= {27'h0, stat_v};
        else
          PRDATA_O <= 32'h0;
      end
    end
  end

  // assertions
  a_psel_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> psel_q == PSEL_RESET)
    else $error("select field not 0101 after reset");
  a_psel_locked: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (wr_misc && !CCR_I.i_bit) |=> $stable(psel_q))
    else $error("select field changed with I clear");
  a_special_once: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!special_q && !init_q) |=> !special_q)
    else $error("special bit set again");
  a_boot_guard: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (wr_misc && !spec_mode && !init_q) |=> $stable(boot_q))
    else $error("boot enable written in normal mode");
  a_vis_once: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (vis_wr_q && !init_q) |=> $stable(vis_q))
    else $error("visibility bit written twice");
  a_stop_s_bit: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_RUN && OP_I.stop_exec && CCR_I.s_bit && !OP_I.wait_exec
     && RST_PIN_N_I) |=> pm_q == PM_RUN)
    else $error("stop entered with S set");
  a_irq_masked: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP && CCR_I.i_bit && NMI_N_I && RST_PIN_N_I)
    |=> pm_q == PM_STOP)
    else $error("masked irq woke stop");
  a_reset_exit: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !RST_PIN_N_I |=> pm_q == PM_RUN)
    else $error("reset pin did not end low power");
  a_nodelay: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP && !NMI_N_I && !dly_en_q && RST_PIN_N_I)
    |=> pm_q == PM_RESUME)
    else $error("delay taken while disabled");
  a_timer_off: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_WAIT && CCR_I.i_bit && !WDOG_EN_I) |=> TIMER_OFF_O)
    else $error("timer not shut off in wait");

  // mode bits and register writes
  a_mode_catch: assert property (@(posedge CLK_I) disable iff (SRST_I)
    init_q |=> (special_q == ~$past(MODE_PIN_B_I)) &&
               (mode_a_q == $past(MODE_PIN_A_I)))
    else $error("mode bits not taken from the mode pins");
  a_psel_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (wr_misc && CCR_I.i_bit) |=> psel_q == $past(PWDATA_I[3:0]))
    else $error("select field write with I set was lost");
  a_top_src: assert property (@(posedge CLK_I) disable iff (SRST_I)
    1'b1 |=> TOP_SRC_O == $past(psel_eff))
    else $error("promoted source does not follow the select field");

  // pin side outputs
  a_boot_window: assert property (@(posedge CLK_I) disable iff (SRST_I)
    BOOT_SEL_O |-> $past(boot_q))
    else $error("boot rom selected while disabled");
  a_vis_drive: assert property (@(posedge CLK_I) disable iff (SRST_I)
    VIS_DRIVE_O |-> $past(expanded && vis_q))
    else $error("internal read driven out without visibility");
  a_bus_clk_low: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!expanded && vis_q) |=> !BUS_CLK_O)
    else $error("bus clock not held low");

  // low-power sequencer: the state must stay one-hot, since every output
  // decode compares against a single state code
  a_pm_onehot: assert property (@(posedge CLK_I) disable iff (SRST_I)
    $onehot(pm_q))
    else $error("sequencer state not one-hot");
  a_halt_level: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP) |=> CLK_HALT_O)
    else $error("clocks not halted in stop");
  a_irq_wake: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP && !IRQ_N_I && !CCR_I.i_bit && RST_PIN_N_I)
    |=> pm_q != PM_STOP)
    else $error("unmasked irq did not wake stop");
  a_nmi_svc: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP && !NMI_N_I && IRQ_N_I && !CCR_I.x_bit &&
     RST_PIN_N_I) |=> svc_q)
    else $error("nmi with X clear not serviced");
  a_nmi_resume: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_STOP && !NMI_N_I && IRQ_N_I && CCR_I.x_bit &&
     RST_PIN_N_I) |=> !svc_q)
    else $error("nmi with X set did not resume");

  // restart delay walk: entry, countdown, then resume and run
  sequence s_stop_nmi_dly;
    pm_q == PM_STOP && !NMI_N_I && RST_PIN_N_I && dly_en_q;
  endsequence
  sequence s_in_delay;
    pm_q == PM_DELAY;
  endsequence
  sequence s_delay_done;
    pm_q == PM_DELAY && dly_cnt_q == 32'h0 && RST_PIN_N_I;
  endsequence
  sequence s_resume_then_run;
    pm_q == PM_RESUME ##1 pm_q == PM_RUN;
  endsequence
  a_delay_entry: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_stop_nmi_dly |=> s_in_delay)
    else $error("restart delay skipped while enabled");
  a_delay_count: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_DELAY && dly_cnt_q != 32'h0 && RST_PIN_N_I)
    |=> s_in_delay and (dly_cnt_q == $past(dly_cnt_q) - 32'h1))
    else $error("restart delay counter did not step down");
  a_delay_exit: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_delay_done |=> s_resume_then_run)
    else $error("restart delay did not end in resume");
  a_resume_pulse: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_RESUME && RST_PIN_N_I)
    |=> (WAKE_SERVICE_O || WAKE_RESUME_O))
    else $error("no wake pulse after resume");

  // wait holds until something unmasked arrives
  a_wait_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_WAIT && !any_int && RST_PIN_N_I) |=> pm_q == PM_WAIT)
    else $error("wait left without an unmasked interrupt");
  a_wait_exit: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (pm_q == PM_WAIT && any_int && RST_PIN_N_I) |=> pm_q == PM_RESUME)
    else $error("unmasked interrupt did not end wait");
  a_reset_pulse: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!RST_PIN_N_I && pm_q != PM_RUN) |=> WAKE_RESET_O)
    else $error("reset pin exit not flagged");
endmodule // prio_misc_ctrl
`default_nettype wire

// File: sim/cpu_pin_model.sv
// partner: cpu core condition codes, instruction strobes, mode and
// interrupt/reset pins, free bus clock; tasks called just after clk_i rises
`timescale 1ns/1ps
`default_nettype none
module cpu_pin_model (
  // cpu side and pins
  input  wire logic                  clk_i,
  output var prio_misc_pkg::ccr_s    ccr_o,
  output var prio_misc_pkg::cpu_op_s op_o,
  output var logic                   mode_b_o,
  output var logic                   mode_a_o,
  output var logic                   irq_n_o,
  output var logic                   nmi_n_o,
  output var logic                   rst_n_o,
  output var logic                   bus_clk_o
);
  import prio_misc_pkg::*;
  // no data bus port: the model never drives data during internal reads
  initial begin
    {ccr_o, op_o, mode_b_o, mode_a_o} = 7'h72;
    {irq_n_o, nmi_n_o, rst_n_o, bus_clk_o} = 4'hE;
  end
  always @(posedge clk_i) begin
    bus_clk_o <= ~bus_clk_o;
  end
  // pins are levels; reset pin low may be driven at any time
  task automatic drive(input ccr_s c, input logic [2:0] pins);
    ccr_o <= c;
    {irq_n_o, nmi_n_o, rst_n_o} <= pins;
  endtask
  task automatic set_mode(input logic [1:0] ba);
    {mode_b_o, mode_a_o} <= ba;
  endtask
  // stop is never issued right after an accumulator inherent opcode,
  // so a lost wake-up is not modelled
  task automatic issue(input cpu_op_s o);
    op_o <= o;
    @(posedge clk_i);
    op_o <= '0;
  endtask
endmodule // cpu_pin_model
`default_nettype wire

// File: sim/tb_prio_misc_ctrl.sv
// testbench: register modes, priority promotion, stop and wait sequencing
// assumes cpu_pin_model drives the cpu and pin inputs of the block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_prio_misc_ctrl;
  import prio_misc_pkg::*;
  localparam int RCYC = 4;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err, sv, rs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cpu_addr, src_req, src_en;
  logic        int_read, wdog_en, mb, ma, irq_n, nmi_n, rst_n, bclk, bclk_o;
  logic        top_valid, boot_sel, vis_drv, halt, toff, w_svc, w_res, w_rst;
  logic [3:0]  top_src;
  logic [7:0]  cur;
  ccr_s        condition_code_reg;
  cpu_op_s     op;
  int          mismatches, check_count, n;
  logic [7:0]  wv [3] = '{8'hF3, 8'h00, 8'h40};
  cpu_pin_model cpu (.clk_i(clk), .ccr_o(condition_code_reg), .op_o(op), .mode_b_o(mb),
    .mode_a_o(ma), .irq_n_o(irq_n), .nmi_n_o(nmi_n), .rst_n_o(rst_n),
    .bus_clk_o(bclk));
  prio_misc_ctrl #(.RESTART_CYCLES(RCYC)) DUT (.CLK_I(clk), .SRST_I(srst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CCR_I(condition_code_reg), .OP_I(op), .CPU_ADDR_I(cpu_addr),
    .INT_READ_I(int_read), .SRC_REQ_I(src_req), .SRC_EN_I(src_en),
    .WDOG_EN_I(wdog_en), .MODE_PIN_A_I(ma), .MODE_PIN_B_I(mb),
    .IRQ_N_I(irq_n), .NMI_N_I(nmi_n), .RST_PIN_N_I(rst_n), .BUS_CLK_I(bclk),
    .TOP_SRC_O(top_src), .TOP_VALID_O(top_valid), .BOOT_SEL_O(boot_sel),
    .VIS_DRIVE_O(vis_drv), .BUS_CLK_O(bclk_o), .CLK_HALT_O(halt),
    .TIMER_OFF_O(toff), .WAKE_SERVICE_O(w_svc), .WAKE_RESUME_O(w_res),
    .WAKE_RESET_O(w_rst));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge clk);
    if (k >= 20) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic do_reset(input logic [1:0] ba);
    cpu.set_mode(ba);
    cpu.drive(3'h7, 3'h7);
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_wake();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (w_svc !== 1'b1 && w_res !== 1'b1 && n < 60);
    {sv, rs} = {w_svc, w_res};
    if (n >= 60) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  function automatic logic [7:0] rst_val(input logic [1:0] ba);
    return {~ba[1] & ~ba[0], ~ba[1], ba[0], ~ba[1] & ba[0], PSEL_RESET};
  endfunction
  // special bit only ever clears; old special state gates this write
  function automatic logic [7:0] wr_val(input logic [7:0] c, w,
                                        input logic first, iset);
    logic [7:0] v;
    v = c;
    if (c[6]) {v[7], v[6], v[5]} = {w[7], w[6], w[5]};
    else if (first) v[5] = w[5];
    if (first) v[4] = w[4];
    if (iset) v[3:0] = w[3:0];
    return v;
  endfunction
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_addr, src_req, src_en, int_read, wdog_en} = '0;
    {mismatches, check_count} = '0;
    void'($urandom(70));
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      cpu_addr <= BOOT_LO | 16'($urandom % 256);
      int_read <= 1'b1;
      apb(1'b0, ADDR_PRIO_MISC, '0);
      cur = rst_val(m[1:0]);
      `CHK("reset value", {24'h0, cur}, rd)
      `CHK("boot select", cur[7], boot_sel)
      `CHK("visibility", cur[5] & cur[4], vis_drv)
      apb(1'b0, ADDR_LOWPWR_CTRL, '0);
      `CHK("delay enable", 32'h1, rd)
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, ADDR_PRIO_MISC, {24'h0, wv[k]});
        cur = wr_val(cur, wv[k], k == 0, 1'b1);
        apb(1'b0, ADDR_PRIO_MISC, '0);
        `CHK("misc write", {24'h0, cur}, rd)
      end
      if (!cur[5] && cur[4]) repeat (4) begin
        @(posedge clk);
        `CHK("bus clock", 1'b0, bclk_o)
      end
      else repeat (4) begin
        @(posedge clk);
        `CHK("bus clock out", ~bclk, bclk_o)
      end
      $display("mode %0d done", m);
    end
    do_reset(2'h2);
    cur = rst_val(2'h2);
    for (int c = 0; c < 16; c++) begin
      cpu.drive(3'h6, 3'h7);
      apb(1'b1, ADDR_PRIO_MISC, 32'(c));
      cur = wr_val(cur, 8'(c), c == 0, 1'b0);
      cpu.drive(3'h7, 3'h7);
      apb(1'b1, ADDR_PRIO_MISC, 32'(c));
      cur = wr_val(cur, 8'(c), 1'b0, 1'b1);
      apb(1'b0, ADDR_PRIO_MISC, '0);
      `CHK("select", {24'h0, cur}, rd)
      n = (c == 5) ? 6 : c;
      src_req <= 16'($urandom) | (16'h1 << n);
      src_en <= 16'($urandom);
      repeat (3) @(posedge clk);
      `CHK("masked", 1'b0, top_valid)
      `CHK("top source", 4'(n), top_src)
      cpu.drive(3'h6, 3'h7);
      repeat (3) @(posedge clk);
      `CHK("promoted", src_req[n] & src_en[n], top_valid)
    end
    apb(1'b0, 12'h0FC, '0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("select done");
    for (int p = 0; p < 2; p++) begin
      do_reset(2'h2);
      apb(1'b1, ADDR_LOWPWR_CTRL, 32'(p == 0));
      cpu.drive({1'b1, p[0], 1'b1}, 3'h7);
      cpu.issue(2'h2);
      repeat (3) @(posedge clk);
      `CHK("stop refused", 1'b0, halt)
      cpu.drive({1'b0, p[0], 1'b1}, 3'h3);
      cpu.issue(2'h2);
      repeat (8) @(posedge clk);
      `CHK("stop held", 1'b1, halt)
      cpu.drive({1'b0, p[0], 1'b1}, 3'h5);
      wait_wake();
      `CHK("wake kind", {~p[0], p[0]}, {sv, rs})
      `CHK("restart delay", p == 0, n > RCYC + 2)
    end
    cpu.drive(3'h0, 3'h7);
    cpu.issue(2'h2);
    cpu.drive(3'h0, 3'h3);
    wait_wake();
    `CHK("irq wake", 1'b1, sv | rs)
    cpu.drive(3'h0, 3'h7);
    repeat (2) @(posedge clk);
    cpu.issue(2'h2);
    repeat (3) @(posedge clk);
    cpu.drive(3'h0, 3'h6);
    repeat (2) @(posedge clk);
    `CHK("reset wake", 1'b1, w_rst)
    $display("stop done");
    for (int w = 0; w < 2; w++) begin
      do_reset(2'h2);
      wdog_en <= w[0];
      cpu.drive(3'h5, 3'h7);
      cpu.issue(2'h1);
      repeat (3) @(posedge clk);
      `CHK("timer off", ~w[0], toff)
      cpu.drive(3'h5, 3'h5);
      wait_wake();
      `CHK("wait exit", 1'b1, sv)
    end
    $display("wait done");
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // tb_prio_misc_ctrl
`default_nettype wire
